// ---- hw/e1tcc_pkg.sv ----
package e1tcc_pkg;
  localparam int NUM_CH = 8;
  localparam int CH_W = $clog2(NUM_CH);
  localparam int CLK_PERIOD_NS = 4;
  localparam int TX_CLK_PERIOD_NS = 48;
  localparam int TX_HALF_CYC = TX_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int DIV_W = $clog2(TX_HALF_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TX_HALF_CYC - 1);
  localparam int ALARM_LIMIT = 128;
  localparam int CNT_W = $clog2(ALARM_LIMIT + 2);
  localparam logic [CNT_W-1:0] CNT_AT_LIMIT = CNT_W'(ALARM_LIMIT);
  localparam logic [CNT_W-1:0] CNT_SAT = CNT_W'(ALARM_LIMIT + 1);
  localparam int REF_LOSS_NS = 2000;
  localparam int REF_LOSS_CYC = REF_LOSS_NS / CLK_PERIOD_NS;
  localparam int GAP_W = $clog2(REF_LOSS_CYC + 1);
  localparam logic [GAP_W-1:0] GAP_MAX = GAP_W'(REF_LOSS_CYC);
  localparam longint REF_FREQ_HZ = 2048000;
  localparam longint SYS_FREQ_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam logic [31:0] REF_PHASE_INC = 32'((REF_FREQ_HZ << 32) / SYS_FREQ_HZ);
  // Device configuration port
  localparam int CFG_AW = 4;
  localparam int CFG_DW = 16;
  localparam logic [CFG_AW-1:0] DCFG_GLOBAL = 4'h8;
  localparam int DCFG_EN_BIT = 0;
  localparam int DCFG_INV_BIT = 0;
  localparam int DCFG_SRAIL_BIT = 1;
  localparam int DSTAT_LOST_BIT = 8;
  localparam int DSTAT_INV_BIT = 9;
  localparam int DSTAT_SRAIL_BIT = 10;
  // Host register map
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] HREG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] HREG_PAT_POS = 8'h04;
  localparam logic [AXI_AW-1:0] HREG_PAT_NEG = 8'h08;
  localparam logic [AXI_AW-1:0] HREG_ALARM = 8'h0c;
  localparam logic [AXI_AW-1:0] HREG_INT_STATUS = 8'h10;
  localparam logic [AXI_AW-1:0] HREG_INT_MASK = 8'h14;
  localparam logic [AXI_AW-1:0] HREG_DEV_STATUS = 8'h18;
  localparam logic [AXI_AW-1:0] HREG_CHAN_BASE = 8'h20;
  localparam int CTRL_GATE_BIT = 0;
  localparam int CTRL_TEST_N_BIT = 1;
  localparam int CTRL_INV_BIT = 2;
  localparam int CTRL_SRAIL_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
  localparam logic [31:0] PAT_POS_RESET = 32'h5555_5555;
  localparam logic [31:0] PAT_NEG_RESET = 32'haaaa_aaaa;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_WAIT, RD_RESP} e1tcc_rd_e;
endpackage

// ---- hw/e1tcc_link_if.sv ----
interface e1tcc_link_if;
  import e1tcc_pkg::*;
  logic [NUM_CH-1:0] tx_facility_clock;
  logic [NUM_CH-1:0] tx_positive_rail;
  logic [NUM_CH-1:0] tx_negative_rail;
  logic global_driver_gate;
  logic in_circuit_test_n;
  logic ref_clock;
  logic [NUM_CH-1:0] line_out_plus;
  logic [NUM_CH-1:0] line_out_minus;
  logic [NUM_CH-1:0] line_oe;
  logic [NUM_CH-1:0] driver_monitor_alarm;
  logic [NUM_CH-1:0] alarm_oe;
  logic cfg_wr;
  logic [CFG_AW-1:0] cfg_addr;
  logic [CFG_DW-1:0] cfg_wdata;
  logic cfg_rd;
  logic [CFG_DW-1:0] cfg_rdata;
  modport device (
    input tx_facility_clock, tx_positive_rail, tx_negative_rail,
    input global_driver_gate, in_circuit_test_n, ref_clock,
    input cfg_wr, cfg_addr, cfg_wdata, cfg_rd,
    output line_out_plus, line_out_minus, line_oe,
    output driver_monitor_alarm, alarm_oe, cfg_rdata
  );
  modport host (
    output tx_facility_clock, tx_positive_rail, tx_negative_rail,
    output global_driver_gate, in_circuit_test_n, ref_clock,
    output cfg_wr, cfg_addr, cfg_wdata, cfg_rd,
    input line_out_plus, line_out_minus, line_oe,
    input driver_monitor_alarm, alarm_oe, cfg_rdata
  );
endinterface

// ---- hw/e1tcc_device.sv ----
module e1tcc_device
  import e1tcc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Framer side pins and configuration port
  e1tcc_link_if.device link,
  // User side status
  output logic ref_clock_lost
);

  // Pin synchronisers
  logic [NUM_CH-1:0] fclk_s1_q;
  logic [NUM_CH-1:0] fclk_s2_q;
  logic [NUM_CH-1:0] fclk_s3_q;
  logic [NUM_CH-1:0] pos_s1_q;
  logic [NUM_CH-1:0] pos_s2_q;
  logic [NUM_CH-1:0] neg_s1_q;
  logic [NUM_CH-1:0] neg_s2_q;
  logic gate_s1_q;
  logic gate_s2_q;
  logic tst_s1_q;
  logic tst_s2_q;
  logic ref_s1_q;
  logic ref_s2_q;
  logic ref_s3_q;

  // Configuration state
  logic [NUM_CH-1:0] chan_en_q;
  logic invert_q;
  logic srail_q;
  logic [CFG_DW-1:0] rdata_q;

  // Line and monitor state
  logic [NUM_CH-1:0] plus_q;
  logic [NUM_CH-1:0] minus_q;
  logic [NUM_CH-1:0] pol_q;
  logic [NUM_CH-1:0] alarm_q;
  logic [NUM_CH-1:0] tx_edge;
  logic [NUM_CH-1:0] plus_d;
  logic [NUM_CH-1:0] minus_d;
  logic [NUM_CH-1:0] drive_en;
  logic [GAP_W-1:0] gap_q;
  logic lost_q;
  logic ref_rise;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fclk_s1_q <= '0;
      fclk_s2_q <= '0;
      fclk_s3_q <= '0;
      pos_s1_q <= '0;
      pos_s2_q <= '0;
      neg_s1_q <= '0;
      neg_s2_q <= '0;
    end else if (clk_en) begin
      fclk_s1_q <= link.tx_facility_clock;
      fclk_s2_q <= fclk_s1_q;
      fclk_s3_q <= fclk_s2_q;
      pos_s1_q <= link.tx_positive_rail;
      pos_s2_q <= pos_s1_q;
      neg_s1_q <= link.tx_negative_rail;
      neg_s2_q <= neg_s1_q;
    end
  end

  // Test pin resets to its released level so the outputs do not glitch
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gate_s1_q <= 1'b0;
      gate_s2_q <= 1'b0;
      tst_s1_q <= 1'b1;
      tst_s2_q <= 1'b1;
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else if (clk_en) begin
      gate_s1_q <= link.global_driver_gate;
      gate_s2_q <= gate_s1_q;
      tst_s1_q <= link.in_circuit_test_n;
      tst_s2_q <= tst_s1_q;
      ref_s1_q <= link.ref_clock;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      chan_en_q <= '0;
      invert_q <= 1'b0;
      srail_q <= 1'b0;
    end else if (clk_en && link.cfg_wr) begin
      if (link.cfg_addr == DCFG_GLOBAL) begin
        invert_q <= link.cfg_wdata[DCFG_INV_BIT];
        srail_q <= link.cfg_wdata[DCFG_SRAIL_BIT];
      end else if (link.cfg_addr < DCFG_GLOBAL) begin
        chan_en_q[link.cfg_addr[CH_W-1:0]] <= link.cfg_wdata[DCFG_EN_BIT];
      end
    end
  end

  // Status word is captured on request, so it is one cycle old when read
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (clk_en && link.cfg_rd) begin
      rdata_q <= '0;
      rdata_q[NUM_CH-1:0] <= alarm_q;
      rdata_q[DSTAT_LOST_BIT] <= lost_q;
      rdata_q[DSTAT_INV_BIT] <= invert_q;
      rdata_q[DSTAT_SRAIL_BIT] <= srail_q;
    end
  end

  assign link.cfg_rdata = rdata_q;

  // Driver enables: test pin overrides everything, gate overrides registers
  assign drive_en = chan_en_q & {NUM_CH{gate_s2_q & tst_s2_q}};

  generate
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [CNT_W-1:0] cnt_q;
      logic mark;

      // Selected edge of the synchronised facility clock
      assign tx_edge[ch] = invert_q ? (fclk_s3_q[ch] & ~fclk_s2_q[ch])
                                    : (~fclk_s3_q[ch] & fclk_s2_q[ch]);

      always_comb begin
        if (srail_q) begin
          // Marks alternate polarity; negative rail not looked at
          plus_d[ch] = pos_s2_q[ch] & ~pol_q[ch];
          minus_d[ch] = pos_s2_q[ch] & pol_q[ch];
        end else begin
          // Both rails high is illegal; positive wins
          plus_d[ch] = pos_s2_q[ch];
          minus_d[ch] = neg_s2_q[ch] & ~pos_s2_q[ch];
        end
      end

      // A pulse counts only if it actually leaves an enabled driver
      assign mark = (plus_d[ch] | minus_d[ch]) & drive_en[ch];

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          plus_q[ch] <= 1'b0;
          minus_q[ch] <= 1'b0;
          pol_q[ch] <= 1'b0;
        end else if (clk_en && tx_edge[ch]) begin
          plus_q[ch] <= plus_d[ch];
          minus_q[ch] <= minus_d[ch];
          if (srail_q && pos_s2_q[ch]) begin
            pol_q[ch] <= ~pol_q[ch];
          end
        end
      end

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          cnt_q <= '0;
          alarm_q[ch] <= 1'b0;
        end else if (clk_en && tx_edge[ch]) begin
          if (mark) begin
            cnt_q <= '0;
            alarm_q[ch] <= 1'b0;
          end else if (cnt_q != CNT_SAT) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == CNT_AT_LIMIT) begin
              alarm_q[ch] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  assign link.line_out_plus = plus_q;
  assign link.line_out_minus = minus_q;
  assign link.line_oe = drive_en;
  assign link.driver_monitor_alarm = alarm_q;
  assign link.alarm_oe = {NUM_CH{tst_s2_q}};

  // Reference watchdog; the reference is only watched, not multiplied up
  assign ref_rise = ref_s2_q & ~ref_s3_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gap_q <= '0;
      lost_q <= 1'b1;
    end else if (clk_en) begin
      if (ref_rise) begin
        gap_q <= '0;
        lost_q <= 1'b0;
      end else if (gap_q != GAP_MAX) begin
        gap_q <= gap_q + 1'b1;
      end else begin
        lost_q <= 1'b1;
      end
    end
  end

  assign ref_clock_lost = lost_q;

endmodule

// ---- hw/e1tcc_host.sv ----
// The register addresses and the AXI4-Lite slave port were left to the implementer.
module e1tcc_host
  import e1tcc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // AXI4-Lite write
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq,
  // Device pins
  e1tcc_link_if.host link
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_chan(input logic [AXI_AW-1:0] a);
    return a[AXI_AW-1:5] == HREG_CHAN_BASE[AXI_AW-1:5];
  endfunction

  logic aw_have_q, w_have_q, bvalid_q;
  logic [AXI_AW-1:0] waddr_q, raddr_q;
  logic [31:0] wdata_q, ctrl_q, pat_pos_q, pat_neg_q, int_mask_q, int_stat_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wval;
  logic [NUM_CH-1:0] chan_en_q, al_s1_q, al_s2_q, al_s3_q;
  logic rvalid_q, cfg_wr_q, cfg_rd_q, commit, hit;
  logic [CFG_AW-1:0] cfg_addr_q;
  logic [CFG_DW-1:0] cfg_wdata_q;
  e1tcc_rd_e rd_q;
  logic [DIV_W-1:0] div_q;
  logic [4:0] bit_q;
  logic fclk_q, launch;
  logic [NUM_CH-1:0] pos_q, neg_q;
  logic [31:0] acc_q;

  assign commit = aw_have_q & w_have_q & ~bvalid_q;
  assign wval = merge(ctrl_q, wdata_q, wstrb_q);
  assign hit = is_chan(waddr_q) || waddr_q == HREG_CTRL || waddr_q == HREG_PAT_POS ||
               waddr_q == HREG_PAT_NEG || waddr_q == HREG_INT_STATUS || waddr_q == HREG_INT_MASK;
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready = ~w_have_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = rd_q == RD_IDLE;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bresp_q <= AXI_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (commit) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= hit ? AXI_OKAY : AXI_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // CTRL and channel register writes also forward the device settings over the config port
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET;
      pat_pos_q <= PAT_POS_RESET;
      pat_neg_q <= PAT_NEG_RESET;
      int_mask_q <= '0;
      chan_en_q <= '0;
      cfg_wr_q <= 1'b0;
      cfg_addr_q <= '0;
      cfg_wdata_q <= '0;
    end else if (clk_en) begin
      cfg_wr_q <= 1'b0;
      if (commit && waddr_q == HREG_CTRL) begin
        ctrl_q <= wval;
        cfg_wr_q <= 1'b1;
        cfg_addr_q <= DCFG_GLOBAL;
        cfg_wdata_q <= '0;
        cfg_wdata_q[DCFG_INV_BIT] <= wval[CTRL_INV_BIT];
        cfg_wdata_q[DCFG_SRAIL_BIT] <= wval[CTRL_SRAIL_BIT];
      end
      if (commit && waddr_q == HREG_PAT_POS) begin
        pat_pos_q <= merge(pat_pos_q, wdata_q, wstrb_q);
      end
      if (commit && waddr_q == HREG_PAT_NEG) begin
        pat_neg_q <= merge(pat_neg_q, wdata_q, wstrb_q);
      end
      if (commit && waddr_q == HREG_INT_MASK) begin
        int_mask_q <= merge(int_mask_q, wdata_q, wstrb_q);
      end
      if (commit && is_chan(waddr_q) && wstrb_q[0]) begin
        chan_en_q[waddr_q[CH_W+1:2]] <= wdata_q[0];
        cfg_wr_q <= 1'b1;
        cfg_addr_q <= CFG_AW'(waddr_q[CH_W+1:2]);
        cfg_wdata_q <= CFG_DW'(wdata_q[0]);
      end
    end
  end

  // Rising alarm sets a sticky bit; a set in the clearing cycle wins
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      al_s1_q <= '0;
      al_s2_q <= '0;
      al_s3_q <= '0;
      int_stat_q <= '0;
    end else if (clk_en) begin
      al_s1_q <= link.driver_monitor_alarm & link.alarm_oe;
      al_s2_q <= al_s1_q;
      al_s3_q <= al_s2_q;
      int_stat_q[NUM_CH-1:0] <= (int_stat_q[NUM_CH-1:0] &
        ~((commit && waddr_q == HREG_INT_STATUS) ? wdata_q[NUM_CH-1:0] : '0)) |
        (al_s2_q & ~al_s3_q);
    end
  end

  assign irq = |(int_stat_q & int_mask_q);

  // Read answers two cycles after the address so device status is fresh
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q <= RD_IDLE;
      raddr_q <= '0;
      cfg_rd_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= AXI_OKAY;
    end else if (clk_en) begin
      cfg_rd_q <= 1'b0;
      unique case (rd_q)
        RD_IDLE: begin
          if (s_axi_arvalid) begin
            raddr_q <= s_axi_araddr;
            cfg_rd_q <= 1'b1;
            rd_q <= RD_FETCH;
          end
        end
        RD_FETCH: rd_q <= RD_WAIT;
        RD_WAIT: begin
          rvalid_q <= 1'b1;
          rresp_q <= AXI_OKAY;
          rd_q <= RD_RESP;
          rdata_q <= '0;
          if (is_chan(raddr_q)) begin
            rdata_q[0] <= chan_en_q[raddr_q[CH_W+1:2]];
          end else begin
            case (raddr_q)
              HREG_CTRL: rdata_q <= ctrl_q;
              HREG_PAT_POS: rdata_q <= pat_pos_q;
              HREG_PAT_NEG: rdata_q <= pat_neg_q;
              HREG_ALARM: rdata_q[NUM_CH-1:0] <= al_s2_q;
              HREG_INT_STATUS: rdata_q <= int_stat_q;
              HREG_INT_MASK: rdata_q <= int_mask_q;
              HREG_DEV_STATUS: rdata_q[CFG_DW-1:0] <= link.cfg_rdata;
              default: rresp_q <= AXI_SLVERR;
            endcase
          end
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            rvalid_q <= 1'b0;
            rd_q <= RD_IDLE;
          end
        end
      endcase
    end
  end

  // Facility clock; data launched on the edge the device does not sample
  assign launch = (div_q == DIV_LAST) && (~fclk_q == ctrl_q[CTRL_INV_BIT]);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= '0;
      fclk_q <= 1'b0;
      bit_q <= '0;
      pos_q <= '0;
      neg_q <= '0;
    end else if (clk_en) begin
      div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
      if (div_q == DIV_LAST) begin
        fclk_q <= ~fclk_q;
      end
      if (launch) begin
        bit_q <= bit_q + 1'b1;
        pos_q <= {NUM_CH{pat_pos_q[bit_q]}};
        neg_q <= ctrl_q[CTRL_SRAIL_BIT] ? '0 :
                 {NUM_CH{pat_neg_q[bit_q] & ~pat_pos_q[bit_q]}};
      end
    end
  end

  // Phase accumulator: average rate matches the reference far inside 50ppm
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= '0;
    end else if (clk_en) begin
      acc_q <= acc_q + REF_PHASE_INC;
    end
  end

  assign link.tx_facility_clock = {NUM_CH{fclk_q}};
  assign link.tx_positive_rail = pos_q;
  assign link.tx_negative_rail = neg_q;
  assign link.global_driver_gate = ctrl_q[CTRL_GATE_BIT];
  assign link.in_circuit_test_n = ctrl_q[CTRL_TEST_N_BIT];
  assign link.ref_clock = acc_q[31];
  assign link.cfg_wr = cfg_wr_q;
  assign link.cfg_addr = cfg_addr_q;
  assign link.cfg_wdata = cfg_wdata_q;
  assign link.cfg_rd = cfg_rd_q;

endmodule

// ---- tb/e1tcc_assertions.sv ----
module e1tcc_assertions
  import e1tcc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link pins
  input wire logic [NUM_CH-1:0] tx_facility_clock,
  input wire logic global_driver_gate,
  input wire logic in_circuit_test_n,
  input wire logic [NUM_CH-1:0] line_out_plus,
  input wire logic [NUM_CH-1:0] line_out_minus,
  input wire logic [NUM_CH-1:0] line_oe,
  input wire logic [NUM_CH-1:0] driver_monitor_alarm,
  input wire logic [NUM_CH-1:0] alarm_oe,
  // Configuration port
  input wire logic cfg_wr,
  input wire logic [CFG_AW-1:0] cfg_addr,
  input wire logic [CFG_DW-1:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TXC = 2 * TX_HALF_CYC;
  logic inv_q;
  logic tx_q;
  logic [3:0] age_q;
  logic [15:0] quiet_q;
  logic pulse;
  logic samp;
  logic inv_wr;
  assign pulse = line_oe[0] && (line_out_plus[0] || line_out_minus[0]);
  assign samp = inv_q ? (tx_q && !tx_facility_clock[0]) : (!tx_q && tx_facility_clock[0]);
  assign inv_wr = cfg_wr && cfg_addr == DCFG_GLOBAL;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) inv_q <= 1'b0;
    else if (inv_wr) inv_q <= cfg_wdata[DCFG_INV_BIT];
  end
  // Edge choice is ambiguous for a few cycles after the invert bit moves
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) age_q <= 4'h0;
    else if (inv_wr && cfg_wdata[DCFG_INV_BIT] != inv_q) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) tx_q <= 1'b0;
    else tx_q <= tx_facility_clock[0];
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) quiet_q <= 16'h0;
    else if (pulse) quiet_q <= 16'h0;
    else if (quiet_q != 16'hffff) quiet_q <= quiet_q + 16'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  power_up_float_a: assert property ($past(sys_rst) |-> line_oe == '0)
    else $error("driver enabled right after reset");
  enable_needs_gate_a: assert property ((line_oe & ~$past(line_oe)) != '0 |->
    $past(global_driver_gate, 2) && $past(in_circuit_test_n, 2))
    else $error("driver enabled without gate");
  gate_low_float_a: assert property (!global_driver_gate [*3] |-> line_oe == '0)
    else $error("driver active with gate low");
  test_pin_float_a: assert property (!in_circuit_test_n [*3] |->
    line_oe == '0 && alarm_oe == '0)
    else $error("output driven in test mode");
  alarm_early_a: assert property ($rose(driver_monitor_alarm[0]) |->
    quiet_q >= 16'(127 * TXC))
    else $error("alarm before quiet interval");
  alarm_late_a: assert property (quiet_q == 16'(131 * TXC) |-> driver_monitor_alarm[0])
    else $error("alarm missing after quiet interval");
  alarm_hold_a: assert property ($rose(driver_monitor_alarm[0]) |->
    driver_monitor_alarm[0] [*8])
    else $error("alarm too short");
  alarm_clear_a: assert property ($fell(driver_monitor_alarm[0]) |-> ##[0:2] quiet_q < 16'd6)
    else $error("alarm cleared without pulse");
  restart_count_a: assert property (quiet_q == 16'd100 |-> !driver_monitor_alarm[0])
    else $error("alarm kept after pulse");
  rail_exclusive_a: assert property ((line_out_plus & line_out_minus) == '0)
    else $error("both line outputs high");
  edge_select_a: assert property (age_q == 4'hf &&
    ($changed(line_out_plus) || $changed(line_out_minus)) |->
    $past(samp, 2) || $past(samp, 3) || $past(samp, 4))
    else $error("line output moved off the sampling edge");
endmodule

// ---- tb/tb_e1_transmit_channel_control.sv ----
module tb_e1_transmit_channel_control
  import e1tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] RC [5] = '{32'h3, 32'h3, 32'h3, 32'hb, 32'hb};
  localparam logic [31:0] RP [5] = '{32'hffffffff, 32'h0, 32'hffffffff, 32'hffffffff, 32'h0};
  localparam logic [31:0] RN [5] = '{32'h0, 32'hffffffff, 32'hffffffff, 32'h0, 32'hffffffff};
  localparam logic [1:0] RE [5] = '{2'b10, 2'b01, 2'b10, 2'b11, 2'b00};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [AXI_AW-1:0] s_axi_awaddr = '0;
  logic [AXI_AW-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, ref_lost;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0] seen;
  int n_fail = 0;
  int check_count = 0;
  always #2 clk_sys = ~clk_sys;
  e1tcc_link_if e1tcc_link_if_i();
  e1tcc_host e1tcc_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .irq(irq), .link(e1tcc_link_if_i));
  e1tcc_device e1tcc_device_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
    .link(e1tcc_link_if_i), .ref_clock_lost(ref_lost));
  e1tcc_assertions e1tcc_assertions_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .tx_facility_clock(e1tcc_link_if_i.tx_facility_clock),
    .global_driver_gate(e1tcc_link_if_i.global_driver_gate),
    .in_circuit_test_n(e1tcc_link_if_i.in_circuit_test_n),
    .line_out_plus(e1tcc_link_if_i.line_out_plus),
    .line_out_minus(e1tcc_link_if_i.line_out_minus), .line_oe(e1tcc_link_if_i.line_oe),
    .driver_monitor_alarm(e1tcc_link_if_i.driver_monitor_alarm),
    .alarm_oe(e1tcc_link_if_i.alarm_oe), .cfg_wr(e1tcc_link_if_i.cfg_wr),
    .cfg_addr(e1tcc_link_if_i.cfg_addr), .cfg_wdata(e1tcc_link_if_i.cfg_wdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is read at the falling edge, so the handshake edge is never raced
  task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    tb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!tb) begin
      @(negedge clk_sys);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    chk(32'(r), 32'(er));
  endtask
  task automatic axi_rd(input logic [AXI_AW-1:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    tr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!tr) begin
      @(negedge clk_sys);
      ta = s_axi_arready;
      tr = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask
  // Gate and test pins reach line_oe through a two-flop sync
  task automatic pins(input logic [7:0] e, input logic [7:0] ea);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'(e1tcc_link_if_i.line_oe), 32'(e));
    chk(32'(e1tcc_link_if_i.alarm_oe), 32'(ea));
    @(posedge clk_sys);
  endtask
  task automatic results();
    $display("Checks %0d, failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    pins(8'h00, 8'hff);
    axi_rd(HREG_CTRL, CTRL_RESET, AXI_OKAY);
    axi_rd(HREG_PAT_POS, PAT_POS_RESET, AXI_OKAY);
    axi_rd(HREG_PAT_NEG, PAT_NEG_RESET, AXI_OKAY);
    axi_rd(8'h1c, 32'h0, AXI_SLVERR);
    axi_wr(HREG_ALARM, 32'h1, AXI_SLVERR);
    for (int i = 0; i < NUM_CH; i++) axi_wr(HREG_CHAN_BASE + 8'(4 * i), 32'h1, AXI_OKAY);
    pins(8'h00, 8'hff);
    axi_wr(HREG_CTRL, 32'h3, AXI_OKAY);
    pins(8'hff, 8'hff);
    axi_wr(HREG_CHAN_BASE + 8'h0c, 32'h0, AXI_OKAY);
    pins(8'hf7, 8'hff);
    axi_wr(HREG_CTRL, 32'h1, AXI_OKAY);
    pins(8'h00, 8'h00);
    axi_wr(HREG_CTRL, 32'h3, AXI_OKAY);
    axi_wr(HREG_CHAN_BASE + 8'h0c, 32'h1, AXI_OKAY);
    axi_wr(HREG_INT_MASK, 32'h1, AXI_OKAY);
    axi_wr(HREG_PAT_POS, 32'h0, AXI_OKAY);
    axi_wr(HREG_PAT_NEG, 32'h0, AXI_OKAY);
    repeat (1450) @(posedge clk_sys);
    axi_rd(HREG_ALARM, 32'h0, AXI_OKAY);
    repeat (200) @(posedge clk_sys);
    axi_rd(HREG_ALARM, 32'hff, AXI_OKAY);
    axi_rd(HREG_INT_STATUS, 32'hff, AXI_OKAY);
    @(negedge clk_sys);
    chk(32'(irq), 32'h1);
    @(posedge clk_sys);
    axi_wr(HREG_INT_STATUS, 32'h1, AXI_OKAY);
    axi_rd(HREG_INT_STATUS, 32'hfe, AXI_OKAY);
    @(negedge clk_sys);
    chk(32'(irq), 32'h0);
    @(posedge clk_sys);
    axi_wr(HREG_PAT_POS, 32'hffffffff, AXI_OKAY);
    repeat (40) @(posedge clk_sys);
    axi_rd(HREG_ALARM, 32'h0, AXI_OKAY);
    for (int k = 0; k < 5; k++) begin
      axi_wr(HREG_CTRL, RC[k], AXI_OKAY);
      axi_wr(HREG_PAT_POS, RP[k], AXI_OKAY);
      axi_wr(HREG_PAT_NEG, RN[k], AXI_OKAY);
      repeat (40) @(posedge clk_sys);
      seen = 2'b00;
      repeat (150) begin
        @(negedge clk_sys);
        seen |= {e1tcc_link_if_i.line_out_plus[0], e1tcc_link_if_i.line_out_minus[0]};
      end
      @(posedge clk_sys);
      chk(32'(seen), 32'(RE[k]));
    end
    axi_wr(HREG_CTRL, 32'h7, AXI_OKAY);
    axi_wr(HREG_PAT_POS, 32'h55555555, AXI_OKAY);
    axi_wr(HREG_PAT_NEG, 32'h0, AXI_OKAY);
    repeat (200) @(posedge clk_sys);
    axi_rd(HREG_DEV_STATUS, 32'h200, AXI_OKAY);
    @(negedge clk_sys);
    chk(32'(ref_lost), 32'h0);
    results();
  end
endmodule
